// ### design/tkpd_pkg.sv
// constants for the touch / keypad power-down controller and its serial port
// assumes a single 40 MHz sys_clk domain with synchronous serial pins
// Notes on behaviour
// - touch power-down opens every panel driver switch
// - touch power-down holds pen interrupt high
// - keypad power-down drives all six columns low
// - keypad power-down stops scan, clears data registers
// - keypad power-up resumes normal scanning
// - keypad power-down keeps keypad interrupt inactive
// - offset 08h bit 1 keypad power-down, reset 0
// - bit 0 touch power-down, reset 0
// - serial output driven only during host transfer; the enable here lags csn by one sys_clk
`default_nettype none

package tkpd_pkg;

  // register map, 7-bit word addresses
  localparam logic [6:0]  ADDR_POWER_DOWN_CONTROL = 7'h08;
  localparam logic [6:0]  ADDR_KEYPAD_DATA_FIRST  = 7'h09;
  localparam logic [6:0]  ADDR_KEYPAD_DATA_SECOND = 7'h0A;

  // power_down_control fields
  localparam int          BIT_TOUCH_POWERDOWN     = 0;
  localparam int          BIT_KEYPAD_POWERDOWN    = 1;
  localparam logic        RST_TOUCH_POWERDOWN     = 1'b0;
  localparam logic        RST_KEYPAD_POWERDOWN    = 1'b0;

  // widths and counts
  localparam int          REG_WIDTH               = 16;
  localparam int          NUM_COLUMNS             = 6;
  localparam int          NUM_PANEL_SWITCHES      = 4;
  localparam logic [3:0]  CMD_LAST_BIT            = 4'h7;
  localparam logic [3:0]  DATA_LAST_BIT           = 4'hF;
  localparam logic [15:0] RST_KEYPAD_DATA         = 16'h0000;

  // serial port frame phases
  typedef enum logic [1:0] {
    TKPD_SER_IDLE = 2'b00,
    TKPD_SER_CMD  = 2'b01,
    TKPD_SER_DATA = 2'b10,
    TKPD_SER_DONE = 2'b11
  } tkpd_ser_state_t;

endpackage : tkpd_pkg

`default_nettype wire

// ### design/tkpd_top.sv
// power-down control for touch front end and keypad scanner, with the
// serial control port that reaches power_down_control
// assumes csn, sclk and din are synchronous to sys_clk and sclk is much
// slower than sys_clk (at least four sys_clk periods per sclk level)
`default_nettype none

module tkpd_top (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // serial control port
  input  wire logic        ser_csn,
  input  wire logic        ser_sclk,
  input  wire logic        ser_din,
  output logic             ser_dout,
  output logic             ser_dout_oe,
  // touch front end
  input  wire logic [3:0]  panel_switch_req,
  input  wire logic        pen_detect_n,
  output logic [3:0]       panel_switch_en,
  output logic             pen_interrupt_n,
  // keypad scanner
  input  wire logic [5:0]  column_drive_req,
  input  wire logic        key_irq_req_n,
  input  wire logic        key_data_valid,
  input  wire logic [15:0] key_data_first_in,
  input  wire logic [15:0] key_data_second_in,
  output logic [5:0]       keypad_column_drive,
  output logic             keypad_scan_en,
  output logic             key_interrupt_n,
  output logic [15:0]      keypad_data_first,
  output logic [15:0]      keypad_data_second,
  // control bits made visible
  output logic             touch_powerdown,
  output logic             keypad_powerdown
);

  tkpd_pkg::tkpd_ser_state_t state_reg;
  logic        sclk_reg;
  logic [3:0]  cnt_reg;
  logic [6:0]  addr_reg;
  logic        read_reg;
  logic [15:0] rx_reg;
  logic [15:0] tx_reg;
  logic        sclk_rise;
  logic        sclk_fall;
  logic [15:0] rx_next;
  logic        wr_strobe;
  logic [15:0] rd_value;

  // edges of the sampled serial clock
  assign sclk_rise = ser_sclk & ~sclk_reg;
  assign sclk_fall = ~ser_sclk & sclk_reg;
  assign rx_next   = {rx_reg[14:0], ser_din};
  assign wr_strobe = (state_reg == tkpd_pkg::TKPD_SER_DATA) & sclk_rise &
                     ~read_reg & (cnt_reg == tkpd_pkg::DATA_LAST_BIT);

  // read mux on the address still being shifted in, so the word is ready
  // before the first data fall; reserved bits and unmapped words read zero
  always_comb begin
    rd_value = 16'h0000;
    unique case (rx_next[6:0])
      tkpd_pkg::ADDR_POWER_DOWN_CONTROL: begin
        rd_value[tkpd_pkg::BIT_TOUCH_POWERDOWN]  = touch_powerdown;
        rd_value[tkpd_pkg::BIT_KEYPAD_POWERDOWN] = keypad_powerdown;
      end
      tkpd_pkg::ADDR_KEYPAD_DATA_FIRST:  rd_value = keypad_data_first;
      tkpd_pkg::ADDR_KEYPAD_DATA_SECOND: rd_value = keypad_data_second;
      default:                           rd_value = 16'h0000;
    endcase
  end

  // sclk edge detector; reset value matches sclk idling low, so no false
  // rise is seen when reset lets go
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sclk_reg <= 1'b0;
    end else begin
      sclk_reg <= ser_sclk;
    end
  end

  // frame sequencer: 8 command bits (read flag, address), then 16 data bits
  // extra clocks after the 24th bit wait in DONE until csn goes high, so
  // only a fresh frame can issue the next command
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= tkpd_pkg::TKPD_SER_IDLE;
      cnt_reg   <= 4'h0;
      addr_reg  <= 7'h00;
      read_reg  <= 1'b0;
      rx_reg    <= 16'h0000;
    end else if (ser_csn) begin
      // raising csn aborts any half frame, nothing is written
      state_reg <= tkpd_pkg::TKPD_SER_IDLE;
      cnt_reg   <= 4'h0;
    end else begin
      unique case (state_reg)
        tkpd_pkg::TKPD_SER_IDLE: begin
          state_reg <= tkpd_pkg::TKPD_SER_CMD;
          cnt_reg   <= 4'h0;
        end
        tkpd_pkg::TKPD_SER_CMD: begin
          if (sclk_rise) begin
            rx_reg  <= rx_next;
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == tkpd_pkg::CMD_LAST_BIT) begin
              read_reg  <= rx_reg[6];
              addr_reg  <= rx_next[6:0];
              cnt_reg   <= 4'h0;
              state_reg <= tkpd_pkg::TKPD_SER_DATA;
            end
          end
        end
        tkpd_pkg::TKPD_SER_DATA: begin
          if (sclk_rise) begin
            rx_reg  <= rx_next;
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == tkpd_pkg::DATA_LAST_BIT) begin
              // further clocks in the same frame are ignored
              state_reg <= tkpd_pkg::TKPD_SER_DONE;
            end
          end
        end
        tkpd_pkg::TKPD_SER_DONE: begin
          // parked until csn rises; a stray pulse cannot start a command
          state_reg <= tkpd_pkg::TKPD_SER_DONE;
        end
      endcase
    end
  end

  // read data: loaded after the command, shifted out on sclk falls; a bit
  // reaches the pin one sys_clk after the fall, long before the next rise
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_reg   <= 16'h0000;
      ser_dout <= 1'b0;
    end else if (state_reg == tkpd_pkg::TKPD_SER_CMD && sclk_rise &&
                 cnt_reg == tkpd_pkg::CMD_LAST_BIT) begin
      tx_reg <= rd_value;
    end else if (state_reg == tkpd_pkg::TKPD_SER_DATA && read_reg &&
                 sclk_fall) begin
      ser_dout <= tx_reg[15];
      tx_reg   <= {tx_reg[14:0], 1'b0};
    end
  end

  // output driver enabled only while csn frames a transfer; the enable
  // lags csn by one clock, the board pull keeps the line defined meanwhile
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ser_dout_oe <= 1'b0;
    end else begin
      ser_dout_oe <= ~ser_csn;
    end
  end

  // power_down_control; only bits 1:0 are stored, reserved bits of a
  // write are dropped here and read back as zero from the mux
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      touch_powerdown  <= tkpd_pkg::RST_TOUCH_POWERDOWN;
      keypad_powerdown <= tkpd_pkg::RST_KEYPAD_POWERDOWN;
    end else if (wr_strobe &&
                 addr_reg == tkpd_pkg::ADDR_POWER_DOWN_CONTROL) begin
      touch_powerdown  <= rx_next[tkpd_pkg::BIT_TOUCH_POWERDOWN];
      keypad_powerdown <= rx_next[tkpd_pkg::BIT_KEYPAD_POWERDOWN];
    end
  end

  // touch gating: switches open, pen interrupt parked high;
  // pen detection is masked here so nothing reaches the host
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      panel_switch_en <= 4'h0;
      pen_interrupt_n <= 1'b1;
    end else if (touch_powerdown) begin
      panel_switch_en <= 4'h0;
      pen_interrupt_n <= 1'b1;
    end else begin
      panel_switch_en <= panel_switch_req;
      pen_interrupt_n <= pen_detect_n;
    end
  end

  // keypad gating; scanner restarts from its own idle on power-up,
  // columns parked low so no key can source current
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      keypad_column_drive <= 6'h00;
      keypad_scan_en      <= 1'b0;
      key_interrupt_n     <= 1'b1;
    end else if (keypad_powerdown) begin
      keypad_column_drive <= 6'h00;
      keypad_scan_en      <= 1'b0;
      key_interrupt_n     <= 1'b1;
    end else begin
      keypad_column_drive <= column_drive_req;
      keypad_scan_en      <= 1'b1;
      key_interrupt_n     <= key_irq_req_n;
    end
  end

  // keypad data: held empty while powered down, loads are dropped;
  // clear beats a same-cycle load so no stale key survives power-down
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      keypad_data_first  <= tkpd_pkg::RST_KEYPAD_DATA;
      keypad_data_second <= tkpd_pkg::RST_KEYPAD_DATA;
    end else if (keypad_powerdown) begin
      keypad_data_first  <= tkpd_pkg::RST_KEYPAD_DATA;
      keypad_data_second <= tkpd_pkg::RST_KEYPAD_DATA;
    end else if (key_data_valid) begin
      keypad_data_first  <= key_data_first_in;
      keypad_data_second <= key_data_second_in;
    end
  end

endmodule : tkpd_top

`default_nettype wire

// ### tb/tkpd_top_properties.sv
// checker: power-down gating and serial enable at tkpd_top ports
// assumes one sys_clk domain; bound onto every tkpd_top
`default_nettype none
module tkpd_chk (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        ser_csn,
  input wire logic        ser_dout_oe,
  input wire logic [3:0]  panel_switch_en,
  input wire logic        pen_interrupt_n,
  input wire logic [5:0]  keypad_column_drive,
  input wire logic        keypad_scan_en,
  input wire logic        key_interrupt_n,
  input wire logic [15:0] keypad_data_first,
  input wire logic [15:0] keypad_data_second,
  input wire logic        touch_powerdown,
  input wire logic        keypad_powerdown
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // gated outputs lag the control bit by one edge
  chk_switch_open: assert property (
    $past(touch_powerdown) |-> panel_switch_en == 4'h0)
    else $error("panel switch closed in power-down");
  chk_pen_high: assert property (
    $past(touch_powerdown) |-> pen_interrupt_n)
    else $error("pen interrupt low in power-down");
  chk_column_low: assert property (
    $past(keypad_powerdown) |-> keypad_column_drive == 6'h00)
    else $error("column driven in power-down");
  chk_data_clear: assert property (
    keypad_powerdown [*2] |-> keypad_data_first == 16'h0000
      && keypad_data_second == 16'h0000)
    else $error("keypad data kept in power-down");
  chk_scan_halt: assert property (
    $past(keypad_powerdown) |-> !keypad_scan_en)
    else $error("scan running in power-down");
  chk_scan_resume: assert property (
    $fell(keypad_powerdown) |=> keypad_scan_en)
    else $error("scan not resumed");
  chk_key_irq_off: assert property (
    $rose(keypad_powerdown) |=> key_interrupt_n [*2])
    else $error("keypad interrupt in power-down");
  // enable mirrors select one edge late, so it stays on one clock past a frame
  chk_dout_oe: assert property (
    ser_dout_oe == !$past(ser_csn))
    else $error("serial output enable wrong");
endmodule : tkpd_chk
bind tkpd_top tkpd_chk tkpd_chk_i (.sys_clk, .rst_n, .ser_csn,
  .ser_dout_oe, .panel_switch_en, .pen_interrupt_n, .keypad_column_drive,
  .keypad_scan_en, .key_interrupt_n, .keypad_data_first,
  .keypad_data_second, .touch_powerdown, .keypad_powerdown);
`default_nettype wire

// ### tb/tkpd_host.sv
// host model: 24-bit serial frames, read flag, address, data
// assumes sys_clk at 40 MHz; sclk high lasts four sys_clk, low lasts eight
`default_nettype none
module tkpd_host (
  input  wire logic sys_clk,
  input  wire logic ser_dout,
  input  wire logic ser_dout_oe,
  output logic      ser_csn,
  output logic      ser_sclk,
  output logic      ser_din
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-up on the board: a released line reads high
  wire dout_line = ser_dout_oe ? ser_dout : 1'b1;
  initial begin
    ser_csn = 1'b1;
    ser_sclk = 1'b0;
    ser_din = 1'b0;
  end
  // one frame; read bits are taken at each of the 16 data-phase sclk rises
  task automatic xfer(input logic rd, input logic [6:0] a,
                      input logic [15:0] w, output logic [15:0] r);
    logic [23:0] f;
    f = {rd, a, w};
    r = 16'h0000;
    @(posedge sys_clk) ser_csn <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      repeat (4) @(posedge sys_clk);
      ser_din <= f[i];
      repeat (4) @(posedge sys_clk);
      ser_sclk <= 1'b1;
      if (i < 16) r[i] = dout_line;
      repeat (4) @(posedge sys_clk);
      ser_sclk <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    ser_csn <= 1'b1;
    // select stays high well over two clocks between frames
    repeat (4) @(posedge sys_clk);
  endtask : xfer
endmodule : tkpd_host
`default_nettype wire

// ### tb/tsc_keypad_power_down_ctrl_test.sv
// bench: power-down register table, gating, clears and reset
// assumes tkpd_top with host model on the serial port
`default_nettype none
module tsc_keypad_power_down_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [15:0] wr; logic [15:0] rd;} tkpd_row_t;
  logic sys_clk = 1'b0, rst_n = 1'b0, vld = 1'b0;
  logic [3:0] sw_req = 4'hA, sw;
  logic [5:0] col_req = 6'h2D, col;
  logic [15:0] d1 = 16'h0000, d2 = 16'h0000, q1, q2, r;
  logic csn, sclk, din, dout, oe, pen, sc, ki, tpd, kpd;
  int mismatches = 0, total_checks = 0;
  // reserved bits written as ones must read back zero
  tkpd_row_t rows [7] = '{'{16'h0000, 16'h0000}, '{16'h0001, 16'h0001},
    '{16'h0002, 16'h0002}, '{16'h0003, 16'h0003}, '{16'hFFFC, 16'h0000},
    '{16'hFFFF, 16'h0003}, '{16'h0000, 16'h0000}};
  tkpd_top tkpd_top_i (.sys_clk, .rst_n, .ser_csn(csn), .ser_sclk(sclk),
    .ser_din(din), .ser_dout(dout), .ser_dout_oe(oe),
    .panel_switch_req(sw_req), .pen_detect_n(1'b0), .panel_switch_en(sw),
    .pen_interrupt_n(pen), .column_drive_req(col_req),
    .key_irq_req_n(1'b0), .key_data_valid(vld), .key_data_first_in(d1),
    .key_data_second_in(d2), .keypad_column_drive(col),
    .keypad_scan_en(sc), .key_interrupt_n(ki), .keypad_data_first(q1),
    .keypad_data_second(q2), .touch_powerdown(tpd),
    .keypad_powerdown(kpd));
  tkpd_host tkpd_host_i (.sys_clk, .ser_dout(dout), .ser_dout_oe(oe),
    .ser_csn(csn), .ser_sclk(sclk), .ser_din(din));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one load pulse from the scanner, then let it settle
  task automatic load(input logic [15:0] a, input logic [15:0] b);
    @(posedge sys_clk) {vld, d1, d2} <= {1'b1, a, b};
    @(posedge sys_clk) vld <= 1'b0;
    @(posedge sys_clk) #1;
  endtask : load
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  // hang guard, far beyond the roughly 150 us of traffic
  initial begin
    #2_000_000;
    mismatches++;
    results();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      tkpd_host_i.xfer(1'b0, 7'h08, rows[i].wr, r);
      tkpd_host_i.xfer(1'b1, 7'h08, 16'h0000, r);
      check(r, rows[i].rd);
      check(16'(sw), rows[i].rd[0] ? 16'h0000 : 16'(sw_req));
      check({15'h0000, pen}, {15'h0000, rows[i].rd[0]});
      check(16'(col), rows[i].rd[1] ? 16'h0000 : 16'(col_req));
      check(16'(sc), 16'(!rows[i].rd[1]));
      check(16'(ki), 16'(rows[i].rd[1]));
    end
    $display("register rows done");
    // load data, then power down clears it and power up keeps it empty
    load(16'h1234, 16'h5678);
    check(q1, 16'h1234);
    check(q2, 16'h5678);
    tkpd_host_i.xfer(1'b0, 7'h08, 16'h0002, r);
    tkpd_host_i.xfer(1'b1, 7'h09, 16'h0000, r);
    check(r, 16'h0000);
    load(16'h9ABC, 16'hDEF0);
    check(q1, 16'h0000);
    tkpd_host_i.xfer(1'b0, 7'h08, 16'h0000, r);
    check(q2, 16'h0000);
    load(16'h9ABC, 16'hDEF0);
    check(q1, 16'h9ABC);
    check(q2, 16'hDEF0);
    tkpd_host_i.xfer(1'b1, 7'h30, 16'h0000, r);
    check(r, 16'h0000);
    $display("data clear done");
    // reset in mid-run returns both bits to powered up
    tkpd_host_i.xfer(1'b0, 7'h08, 16'h0003, r);
    @(posedge sys_clk) rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    check({14'h0000, kpd, tpd}, 16'h0000);
    tkpd_host_i.xfer(1'b1, 7'h08, 16'h0000, r);
    check(r, 16'h0000);
    $display("reset test done");
    results();
  end
endmodule : tsc_keypad_power_down_ctrl_test
`default_nettype wire
